// ===== src/timer_io_pkg.sv
package timer_io_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] io_ch0_high_addr = 8'h00;
  localparam logic [7:0] io_ch0_low_addr = 8'h04;
  localparam logic [7:0] io_ch1_addr = 8'h08;
  localparam logic [7:0] timer_ctrl_addr = 8'h0c;
  localparam logic [7:0] pin_status_addr = 8'h10;
  localparam logic [7:0] capture0_addr = 8'h14;
  localparam logic [7:0] capture1_addr = 8'h18;
  localparam logic [7:0] capture2_addr = 8'h1c;

  // ----------------------------------------------------------------
  // field layout and reset values
  // ----------------------------------------------------------------
  localparam int field_hi = 7;
  localparam int field_lo = 4;
  localparam logic [7:0] io_reset_value = 8'h00;
  localparam logic [4:0] ctrl_reset_value = 5'h00;
  localparam int ctrl_start0_bit = 0;
  localparam int ctrl_start1_bit = 1;
  localparam int ctrl_buffer_bit = 2;
  localparam int ctrl_pwm2_ch0_bit = 3;
  localparam int ctrl_pwm2_ch1_bit = 4;
  localparam int unit_count = 3;

  // ----------------------------------------------------------------
  // field codes
  // ----------------------------------------------------------------
  localparam logic [1:0] act_none = 2'h0;
  localparam logic [1:0] act_low = 2'h1;
  localparam logic [1:0] act_high = 2'h2;
  localparam logic [1:0] act_toggle = 2'h3;
  localparam logic [1:0] class_compare0 = 2'h0;
  localparam logic [1:0] class_compare1 = 2'h1;
  localparam logic [1:0] class_capture = 2'h2;
  localparam logic [1:0] edge_rise = 2'h0;
  localparam logic [1:0] edge_fall = 2'h1;

endpackage : timer_io_pkg

// ===== src/timer_io_ctrl.sv
// How it works
// R01 - upper nibble of ch0 high and ch1 registers sets second register's function
// R02 - upper nibble of ch0 low register sets ch0 fourth register's function, same code
// R03 - code 0x01: compare output, pin low at match, bit 6 initial level
// R04 - code 0x10: compare output, pin high at match, bit 6 initial level
// R05 - code 0x11: compare output toggles on each match, bit 6 initial level
// R06 - code 1000: capture counter on rising edge of capture pin
// R07 - code 1001: capture counter on falling edge of capture pin
// R08 - code 101x: capture counter on both edges of capture pin
// R09 - fourth register buffered: its field ignored, no capture nor compare
// R10 - codes 0000 and 0100 disable output; 11xx prohibited, treated as off
// R11 - all io control registers clear to zero on reset and standby
// R12 - initial level applied while the channel counter is stopped
// R13 - pwm mode 2: initial level driven when counter clears to zero
`timescale 1ns/1ps
`default_nettype none

module timer_io_ctrl #(
  parameter int count_width = 16
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic standby,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [count_width-1:0] ch0_count,
  input wire logic [count_width-1:0] ch1_count,
  input wire logic ch0_count_clear,
  input wire logic ch1_count_clear,
  input wire logic [timer_io_pkg::unit_count-1:0] compare_match,
  input wire logic [timer_io_pkg::unit_count-1:0] capture_pin_in,
  output logic [timer_io_pkg::unit_count-1:0] compare_pin_out,
  output logic [timer_io_pkg::unit_count-1:0] compare_pin_oe,
  output logic [timer_io_pkg::unit_count-1:0] capture_strobe
);
  import timer_io_pkg::*;

  if (count_width < 1 || count_width > 32) begin : g_width_check
    $error("count_width must be 1 to 32");
  end

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [7:0] io_control_ch0_high;
  logic [7:0] io_control_ch0_low;
  logic [7:0] io_control_ch1;
  logic [4:0] timer_ctrl;
  logic [7:0] next_io_control_ch0_high;
  logic [7:0] next_io_control_ch0_low;
  logic [7:0] next_io_control_ch1;
  logic [4:0] next_timer_ctrl;
  logic [count_width-1:0] capture_value [unit_count];
  logic wr_en;
  logic addr_hit;
  logic wr_ch0_high;
  logic wr_ch0_low;
  logic wr_ch1;
  logic wr_ctrl;

  assign wr_en = psel && penable && pwrite;
  assign pready = 1'b1;
  assign wr_ch0_high = wr_en && (paddr == io_ch0_high_addr);
  assign wr_ch0_low = wr_en && (paddr == io_ch0_low_addr);
  assign wr_ch1 = wr_en && (paddr == io_ch1_addr);
  assign wr_ctrl = wr_en && (paddr == timer_ctrl_addr);

  always_comb begin
    unique case (paddr)
      io_ch0_high_addr, io_ch0_low_addr, io_ch1_addr, timer_ctrl_addr,
      pin_status_addr, capture0_addr, capture1_addr, capture2_addr: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
    pslverr = psel && penable && !addr_hit;
  end

  always_comb begin
    next_io_control_ch0_high = io_control_ch0_high;
    next_io_control_ch0_low = io_control_ch0_low;
    next_io_control_ch1 = io_control_ch1;
    // standby wins over a write in the same cycle
    if (standby) begin
      next_io_control_ch0_high = io_reset_value; // R11
      next_io_control_ch0_low = io_reset_value; // R11
      next_io_control_ch1 = io_reset_value; // R11
    end else begin
      if (wr_ch0_high) next_io_control_ch0_high = pwdata[7:0]; // R01
      if (wr_ch0_low) next_io_control_ch0_low = pwdata[7:0]; // R02
      if (wr_ch1) next_io_control_ch1 = pwdata[7:0]; // R01
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      io_control_ch0_high <= io_reset_value; // R11
      io_control_ch0_low <= io_reset_value; // R11
      io_control_ch1 <= io_reset_value; // R11
    end else begin
      io_control_ch0_high <= next_io_control_ch0_high;
      io_control_ch0_low <= next_io_control_ch0_low;
      io_control_ch1 <= next_io_control_ch1;
    end
  end

  // ----------------------------------------------------------------
  // timer control
  // ----------------------------------------------------------------
  logic ch0_start;
  logic ch1_start;
  logic buffer_on;
  logic ch0_pwm2;
  logic ch1_pwm2;

  always_comb begin
    next_timer_ctrl = timer_ctrl;
    if (wr_ctrl) next_timer_ctrl = pwdata[4:0];
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      timer_ctrl <= ctrl_reset_value;
    end else begin
      timer_ctrl <= next_timer_ctrl;
    end
  end

  // counter starts, fourth-register buffering, pwm2 per channel
  assign ch0_start = timer_ctrl[ctrl_start0_bit];
  assign ch1_start = timer_ctrl[ctrl_start1_bit];
  assign buffer_on = timer_ctrl[ctrl_buffer_bit];
  assign ch0_pwm2 = timer_ctrl[ctrl_pwm2_ch0_bit];
  assign ch1_pwm2 = timer_ctrl[ctrl_pwm2_ch1_bit];

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  logic [31:0] next_prdata;
  logic [31:0] read_word;
  logic rd_setup;

  // load in the setup cycle so the word stands for the whole access phase
  assign rd_setup = psel && !penable && !pwrite;

  always_comb begin
    read_word = 32'h0000_0000;
    unique case (paddr)
      io_ch0_high_addr: read_word[7:0] = io_control_ch0_high;
      io_ch0_low_addr: read_word[7:0] = io_control_ch0_low;
      io_ch1_addr: read_word[7:0] = io_control_ch1;
      timer_ctrl_addr: read_word[4:0] = timer_ctrl;
      pin_status_addr: begin
        // pin levels, output enables, capture pins
        read_word[2:0] = compare_pin_out;
        read_word[10:8] = compare_pin_oe;
        read_word[18:16] = capture_pin_in;
      end
      capture0_addr: read_word[count_width-1:0] = capture_value[0];
      capture1_addr: read_word[count_width-1:0] = capture_value[1];
      capture2_addr: read_word[count_width-1:0] = capture_value[2];
      default: read_word = 32'h0000_0000;
    endcase
  end

  always_comb begin
    next_prdata = prdata;
    if (rd_setup) next_prdata = read_word;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= next_prdata;
    end
  end

  // ----------------------------------------------------------------
  // per-unit wiring: 0 = ch0 second, 1 = ch0 fourth, 2 = ch1 second
  // ----------------------------------------------------------------
  logic [3:0] unit_field [unit_count];
  logic [unit_count-1:0] unit_start;
  logic [unit_count-1:0] unit_pwm2;
  logic [unit_count-1:0] unit_clear;
  logic [unit_count-1:0] unit_blocked;
  logic [count_width-1:0] unit_count_val [unit_count];

  assign unit_field[0] = io_control_ch0_high[field_hi:field_lo]; // R01
  assign unit_field[1] = io_control_ch0_low[field_hi:field_lo]; // R02
  assign unit_field[2] = io_control_ch1[field_hi:field_lo]; // R01
  assign unit_start = {ch1_start, ch0_start, ch0_start};
  assign unit_pwm2 = {ch1_pwm2, ch0_pwm2, ch0_pwm2};
  assign unit_clear = {ch1_count_clear, ch0_count_clear, ch0_count_clear};
  assign unit_blocked = {1'b0, buffer_on, 1'b0}; // R09
  assign unit_count_val[0] = ch0_count;
  assign unit_count_val[1] = ch0_count;
  assign unit_count_val[2] = ch1_count;

  // ----------------------------------------------------------------
  // compare output and input capture units
  // ----------------------------------------------------------------
  for (genvar u = 0; u < unit_count; u++) begin : g_unit
    logic [1:0] field_class;
    logic [1:0] action;
    logic init_level;
    logic is_compare;
    logic is_capture;
    logic edge_hit;
    logic pin_prev;
    logic level;
    logic strobe;
    logic [count_width-1:0] cap;
    logic next_pin_prev;
    logic next_level;
    logic next_strobe;
    logic [count_width-1:0] next_cap;

    assign field_class = unit_field[u][3:2];
    assign action = unit_field[u][1:0];
    assign init_level = unit_field[u][2];

    // mode decode; a buffered fourth register neither captures nor compares
    always_comb begin
      is_compare = !unit_blocked[u] && (field_class == class_compare0
        || field_class == class_compare1) && action != act_none; // R10
      is_capture = !unit_blocked[u] && field_class == class_capture; // R09
    end

    // edge tracker
    always_comb begin
      next_pin_prev = capture_pin_in[u];
      if (action[1]) begin
        edge_hit = capture_pin_in[u] != pin_prev; // R08
      end else if (action == edge_fall) begin
        edge_hit = pin_prev && !capture_pin_in[u]; // R07
      end else begin
        edge_hit = !pin_prev && capture_pin_in[u]; // R06
      end
    end

    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        pin_prev <= 1'b0;
      end else begin
        pin_prev <= next_pin_prev;
      end
    end

    // capture strobe and latched count
    always_comb begin
      next_strobe = is_capture && edge_hit;
      next_cap = cap;
      if (next_strobe) next_cap = unit_count_val[u];
    end

    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        strobe <= 1'b0;
        cap <= '0;
      end else begin
        strobe <= next_strobe;
        cap <= next_cap;
      end
    end

    // compare level: stopped counter, then pwm2 clear, then match
    always_comb begin
      next_level = level;
      if (is_compare) begin
        if (!unit_start[u]) begin
          next_level = init_level; // R12
        end else if (unit_pwm2[u] && unit_clear[u]) begin
          next_level = init_level; // R13
        end else if (compare_match[u]) begin
          unique case (action)
            act_low: next_level = 1'b0; // R03
            act_high: next_level = 1'b1; // R04
            act_toggle: next_level = !level; // R05
            default: next_level = level;
          endcase
        end
      end
    end

    // level holds while the output is disabled
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        level <= 1'b0;
      end else begin
        level <= next_level;
      end
    end

    assign compare_pin_out[u] = level;
    assign compare_pin_oe[u] = is_compare; // R10
    assign capture_strobe[u] = strobe;
    assign capture_value[u] = cap;
  end

endmodule : timer_io_ctrl
`default_nettype wire

// ===== verification/timer_io_ctrl_chk.sv
`timescale 1ns/1ps
`default_nettype none
module timer_io_ctrl_chk
  import timer_io_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic standby,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [timer_io_pkg::unit_count-1:0] capture_pin_in,
  input wire logic [timer_io_pkg::unit_count-1:0] compare_pin_oe,
  input wire logic [timer_io_pkg::unit_count-1:0] capture_strobe
);
  // ------------------------------------
  // port relations
  // ------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  wire logic acc = psel && penable;
  wire logic mapped = (paddr[1:0] == 2'h0) && (paddr <= capture2_addr);
  pready_high_a: assert property (pready) else $error("pready low");
  reset_clear_a: assert property ($fell(rst) |-> compare_pin_oe == 3'h0
    && capture_strobe == 3'h0) else $error("outputs not clear after reset");
  unmapped_err_a: assert property (acc && !mapped |-> pslverr)
    else $error("no error on unmapped access");
  mapped_ok_a: assert property (acc && mapped |-> !pslverr)
    else $error("error on mapped access");
  io_upper_zero_a: assert property (acc && !pwrite && mapped && paddr <= io_ch1_addr
    |-> prdata[31:8] == 24'h0) else $error("io register upper bits set");
  standby_clear_a: assert property (standby |=> compare_pin_oe == 3'h0)
    else $error("output enabled after standby");
  for (genvar u = 0; u < unit_count; u++) begin : g_unit
    edge_cause_a: assert property (capture_strobe[u] |->
      $past(capture_pin_in[u]) != $past(capture_pin_in[u], 2)) else $error("strobe without edge");
    capture_not_compare_a: assert property (compare_pin_oe[u] && $past(compare_pin_oe[u])
      |-> !capture_strobe[u]) else $error("capture while in compare mode");
  end
endmodule : timer_io_ctrl_chk
bind timer_io_ctrl timer_io_ctrl_chk i_timer_io_ctrl_chk (.core_clk(core_clk), .rst(rst),
  .standby(standby), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .capture_pin_in(capture_pin_in),
  .compare_pin_oe(compare_pin_oe), .capture_strobe(capture_strobe));
`default_nettype wire

// ===== verification/timer_io_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
module timer_io_ctrl_bench;
  import timer_io_pkg::*;
  logic core_clk = 0, rst = 1, standby = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rv;
  logic pready, pslverr, c0clr = 0, c1clr = 0;
  logic [15:0] cnt = 16'h0;
  logic [2:0] cm = 3'h0, cp = 3'h0, po, oe, cs;
  int bad_count = 0, checks_done = 0, cyc = 0;
  localparam logic [7:0] ioa [3] = '{io_ch0_high_addr, io_ch0_low_addr, io_ch1_addr};
  localparam logic [7:0] cpa [3] = '{capture0_addr, capture1_addr, capture2_addr};
  localparam logic [7:0] cc [6] = '{8'h10, 8'h50, 8'h20, 8'h60, 8'h30, 8'h70};
  localparam logic [2:0] ce [6] = '{3'h0, 3'h1, 3'h6, 3'h7, 3'h2, 3'h5};
  localparam logic [7:0] kc [5] = '{8'h80, 8'h90, 8'ha0, 8'hb0, 8'hc0};
  localparam logic [1:0] ke [5] = '{2'h1, 2'h2, 2'h3, 2'h3, 2'h0};
  timer_io_ctrl i_timer_io_ctrl (.core_clk(core_clk), .rst(rst), .standby(standby),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ch0_count(cnt), .ch1_count(cnt),
    .ch0_count_clear(c0clr), .ch1_count_clear(c1clr), .compare_match(cm),
    .capture_pin_in(cp), .compare_pin_out(po), .compare_pin_oe(oe), .capture_strobe(cs));
  // ------------------------------------
  // shared tasks
  // ------------------------------------
  initial forever #12.5 core_clk = ~core_clk;
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      conclude();
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    rv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask : apb
  task automatic cmp(input int u, input logic [7:0] code, input logic [2:0] e);
    apb(1, timer_ctrl_addr, 32'h0);
    apb(1, ioa[u], {24'h0, code});
    @(posedge core_clk);
    #1;
    chk(po[u], e[0]);
    chk(oe[u], 1'b1);
    apb(1, timer_ctrl_addr, (u == 2) ? 32'h2 : 32'h1);
    for (int k = 1; k < 3; k++) begin
      @(posedge core_clk);
      cm[u] <= 1'b1;
      @(posedge core_clk);
      cm[u] <= 1'b0;
      #1;
      chk(po[u], e[k]);
    end
  endtask : cmp
  task automatic cap(input int u, input logic [7:0] code, input logic [1:0] e);
    int n;
    apb(1, ioa[u], {24'h0, code});
    for (int k = 0; k < 2; k++) begin
      n = 0;
      @(posedge core_clk);
      cnt <= {code, 7'h0, k[0]};
      cp[u] <= ~k[0];
      repeat (3) begin
        @(posedge core_clk);
        #1;
        n += cs[u];
      end
      chk(n, e[k]);
      if (e[k]) begin
        apb(0, cpa[u], 32'h0);
        chk(rv, {16'h0, code, 7'h0, k[0]});
      end
    end
  endtask : cap
  // ------------------------------------
  // scenarios
  // ------------------------------------
  task automatic regs();
    for (int u = 0; u < 3; u++) begin
      apb(0, ioa[u], 32'h0);
      chk(rv, 32'h0);
      apb(1, ioa[u], 32'hffff_ff5a);
      apb(0, ioa[u], 32'h0);
      chk(rv, 32'h5a);
    end
    apb(0, 8'h24, 32'h0);
    chk(err, 1'b1);
  endtask : regs
  task automatic buf_t();
    apb(1, timer_ctrl_addr, 32'h5);
    apb(1, io_ch0_low_addr, 32'h30);
    chk(oe[1], 1'b0);
    cap(1, 8'h80, 2'h0);
    apb(1, timer_ctrl_addr, 32'h0);
  endtask : buf_t
  task automatic stby_pwm();
    apb(1, io_ch1_addr, 32'h30);
    @(posedge core_clk);
    standby <= 1'b1;
    @(posedge core_clk);
    standby <= 1'b0;
    apb(0, io_ch1_addr, 32'h0);
    chk(rv, 32'h0);
    apb(1, io_ch0_high_addr, 32'h70);
    apb(1, timer_ctrl_addr, 32'h9);
    @(posedge core_clk);
    cm[0] <= 1'b1;
    @(posedge core_clk);
    cm[0] <= 1'b0;
    #1;
    chk(po[0], 1'b0);
    @(posedge core_clk);
    c0clr <= 1'b1;
    @(posedge core_clk);
    c0clr <= 1'b0;
    #1;
    chk(po[0], 1'b1);
    apb(0, pin_status_addr, 32'h0);
    chk({rv[8], rv[0]}, 2'h3);
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    #1;
    chk(po[0], 1'b0);
    apb(0, io_ch0_high_addr, 32'h0);
    chk(rv, 32'h0);
  endtask : stby_pwm
  initial begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    regs();
    for (int u = 0; u < 3; u++) begin
      for (int c = 0; c < 6; c++) cmp(u, cc[c], ce[c]);
      apb(1, ioa[u], 32'h40);
      chk(oe[u], 1'b0);
      for (int c = 0; c < 5; c++) cap(u, kc[c], ke[c]);
    end
    buf_t();
    stby_pwm();
    conclude();
  end
endmodule : timer_io_ctrl_bench
`default_nettype wire
